/* rtl/pssq_cfg.svh */
// Purpose: constants of the paging packet sequencer
// Assumes: one block holds eight word positions in each phase
// Notes:   definitions only
`ifndef PSSQ_CFG_SVH
`define PSSQ_CFG_SVH
`define PSSQ_POS_W 7
`define PSSQ_DATA_W 21
`define PSSQ_AUX_W 14
`define PSSQ_SLOT_W 3
`define PSSQ_SLOTS 8
`define PSSQ_LAST_SLOT 3'h7
`define PSSQ_FIRST_POS 7'h00
`define PSSQ_NPH_6400 2'h3
`define PSSQ_NPH_3200 2'h1
`define PSSQ_NPH_1600 2'h0
`define PSSQ_FIFO_DEPTH 2
`endif

/* rtl/pssq_pkg.sv */
// Purpose: types of the paging packet sequencer
// Assumes: constants come from pssq_cfg.svh
// Notes:   word and packet carriers are packed structs
`include "pssq_cfg.svh"
package pssq_pkg;
   // kind of a decoded word and of a packet
   typedef enum logic [2:0] {
      PSSQ_K_IDLE = 3'h0,
      PSSQ_K_BIW = 3'h1,
      PSSQ_K_ADDR = 3'h2,
      PSSQ_K_LADDR1 = 3'h3,
      PSSQ_K_LADDR2 = 3'h4,
      PSSQ_K_VEC = 3'h5,
      PSSQ_K_LVEC = 3'h6,
      PSSQ_K_MSG = 3'h7
   } pssq_kind_e;
   // signal rate selects the phase count
   typedef enum logic [1:0] {
      PSSQ_R1600 = 2'h0,
      PSSQ_R3200 = 2'h1,
      PSSQ_R6400 = 2'h2
   } pssq_rate_e;
   // walker states
   typedef enum logic [0:0] {
      PSSQ_COLLECT,
      PSSQ_WALK
   } pssq_state_e;
   // one decoded word from the frame decoder
   typedef struct packed {
      pssq_kind_e kind;
      logic [1:0] phase;
      logic [`PSSQ_POS_W-1:0] word_position;
      logic [`PSSQ_DATA_W-1:0] data;
      logic [`PSSQ_AUX_W-1:0] aux;
      logic block_end;
   } pssq_word_s;
   // one packet toward the host port
   typedef struct packed {
      pssq_kind_e kind;
      logic [1:0] phase;
      logic [`PSSQ_POS_W-1:0] word_position;
      logic [2*`PSSQ_DATA_W-1:0] data;
      logic [`PSSQ_AUX_W-1:0] aux;
   } pssq_pkt_s;
endpackage : pssq_pkg

/* rtl/pssq_sequencer.sv */
// Purpose: orders and forms host packets from one received block at a time
// Assumes: the decoder marks each word's kind, phase and position and flags the last word of a block
// Notes:   words are gathered per block, then walked phase by phase in ascending position
`timescale 1ns/1ps
`default_nettype none
`include "pssq_cfg.svh"

// Functional notes
// R1: gather a whole block, then emit phase A fully before later phases.
// R2: drop the block info word at word position zero of every phase.
// R3: forward other block info words only when reporting is enabled.
// R4: walk four phases at 6400, two at 3200, one at 1600 bps.
// R5: send an address packet per short address; its vector follows later.
// R6: address packet carries the word position of its vector.
// R7: vector packet carries the word position range of its message words.
// R8: merge both long address words into one long address packet.
// R9: word after a long vector is sent as the first message packet; not done for a vector at a phase's last slot.
// R10: each message packet carries one word with its position and phase.
// R11: host links address, vector and message packets by word position.
// R12: host may use block info packets for time setting.
// R13: within one phase of a block, packets follow ascending word position.
module pssq_sequencer import pssq_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // configuration
   input wire logic biw_report_en,
   input wire pssq_rate_e rate,
   // decoded word stream
   input wire logic word_valid,
   output logic word_ready,
   input wire pssq_word_s word_in,
   // packet stream toward the host port
   output logic pkt_valid,
   input wire logic pkt_ready,
   output pssq_pkt_s pkt_out
);
   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_q;
   logic rst_n_q;
   pssq_state_e state_q;
   pssq_word_s slot_mem [0:4*`PSSQ_SLOTS-1];
   logic [4*`PSSQ_SLOTS-1:0] slot_ok_q;
   logic [4:0] walk_idx_q;
   logic [1:0] nph;
   logic walk_last;
   pssq_word_s cur;
   logic cur_ok;
   logic [`PSSQ_DATA_W-1:0] laddr_hi_q;
   logic lmsg_next_q;
   logic push;
   pssq_pkt_s push_pkt;
   logic emit;
   logic fifo_in_ready;
   pssq_pkt_s fifo_mem [0:`PSSQ_FIFO_DEPTH-1];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;
   logic pop;

   // slot index of a word inside the block store
   function automatic logic [4:0] slot_of(input logic [1:0] ph, input logic [`PSSQ_POS_W-1:0] pos);
      slot_of = {ph, pos[`PSSQ_SLOT_W-1:0]};
   endfunction : slot_of

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // index of the last walked phase from the signal rate
   always_comb begin
      unique case (rate)
         PSSQ_R6400: nph = `PSSQ_NPH_6400; // R4
         PSSQ_R3200: nph = `PSSQ_NPH_3200; // R4
         default: nph = `PSSQ_NPH_1600; // R4
      endcase
   end

   assign word_ready = (state_q == PSSQ_COLLECT);
   assign cur = slot_mem[walk_idx_q];
   assign cur_ok = slot_ok_q[walk_idx_q];
   assign walk_last = (walk_idx_q[4:3] == nph) && (walk_idx_q[2:0] == `PSSQ_LAST_SLOT);
   assign emit = (state_q == PSSQ_WALK) && fifo_in_ready;

   ////////////////////////////////////////////////////////////////////////
   // block store: gather words during collect, clear after the walk
   always_ff @(posedge ref_clk) begin
      if (word_valid && word_ready) begin
         slot_mem[slot_of(word_in.phase, word_in.word_position)] <= word_in;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         slot_ok_q <= '0;
      end else if (word_valid && word_ready) begin
         slot_ok_q[slot_of(word_in.phase, word_in.word_position)] <= 1'b1;
      end else if (emit && walk_last) begin
         slot_ok_q <= '0;
      end
   end

   // walker: one block at a time, phase by phase, ascending slot
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= PSSQ_COLLECT;
         walk_idx_q <= '0;
      end else begin
         unique case (state_q)
            PSSQ_COLLECT: begin
               if (word_valid && word_in.block_end) begin
                  state_q <= PSSQ_WALK; // R1
                  walk_idx_q <= '0;
               end
            end
            PSSQ_WALK: begin
               if (emit) begin
                  walk_idx_q <= walk_idx_q + 5'h01; // R1 R13
                  if (walk_last) begin
                     state_q <= PSSQ_COLLECT; // R4
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // packet forming for the slot under the walker
   always_comb begin
      push = 1'b0;
      push_pkt = '0;
      push_pkt.kind = cur.kind;
      push_pkt.phase = cur.phase;
      push_pkt.word_position = cur.word_position;
      push_pkt.data = {{`PSSQ_DATA_W{1'b0}}, cur.data}; // R10
      push_pkt.aux = cur.aux; // R6 R7
      if (emit && cur_ok) begin
         if (lmsg_next_q) begin
            push = 1'b1;
            push_pkt.kind = PSSQ_K_MSG; // R9
         end else begin
            unique case (cur.kind)
               PSSQ_K_BIW: push = biw_report_en && (cur.word_position != `PSSQ_FIRST_POS); // R2 R3
               PSSQ_K_ADDR, PSSQ_K_VEC, PSSQ_K_LVEC, PSSQ_K_MSG: push = 1'b1; // R5 R7 R10
               PSSQ_K_LADDR2: begin
                  push = 1'b1;
                  push_pkt.data = {laddr_hi_q, cur.data}; // R8
               end
               default: push = 1'b0;
            endcase
         end
      end
   end

   // long address first word and long vector follow-on
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         laddr_hi_q <= '0;
         lmsg_next_q <= 1'b0;
      end else if (emit) begin
         if (cur_ok && !lmsg_next_q && cur.kind == PSSQ_K_LADDR1) begin
            laddr_hi_q <= cur.data; // R8
         end
         // the follow-on word stays inside the phase; a vector at a phase's last slot has none here
         lmsg_next_q <= cur_ok && !lmsg_next_q && (cur.kind == PSSQ_K_LVEC) && (walk_idx_q[2:0] != `PSSQ_LAST_SLOT); // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry packet buffer; a stalled host holds the walker
   assign fifo_in_ready = (count_q != 2'h2);
   assign pkt_valid = (count_q != 2'h0);
   assign pkt_out = fifo_mem[rd_ptr_q];
   assign pop = pkt_valid && pkt_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         fifo_mem[wr_ptr_q] <= push_pkt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         wr_ptr_q <= wr_ptr_q ^ push;
         rd_ptr_q <= rd_ptr_q ^ pop;
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks on the packet order and content
   logic [1:0] last_ph_q;
   logic [`PSSQ_POS_W-1:0] last_pos_q;
   logic any_q;
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         last_ph_q <= '0;
         last_pos_q <= '0;
         any_q <= 1'b0;
      end else if (state_q == PSSQ_COLLECT) begin
         any_q <= 1'b0;
      end else if (push) begin
         last_ph_q <= push_pkt.phase;
         last_pos_q <= push_pkt.word_position;
         any_q <= 1'b1;
      end
   end

   // previous visited slot and long vector follow-on, judged from what was sent
   logic prev_laddr1_q;
   logic [`PSSQ_DATA_W-1:0] prev_data_q;
   logic after_lvec_q;
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         prev_laddr1_q <= 1'b0;
         prev_data_q <= '0;
         after_lvec_q <= 1'b0;
      end else if (emit) begin
         prev_laddr1_q <= cur_ok && !after_lvec_q && (cur.kind == PSSQ_K_LADDR1);
         prev_data_q <= cur.data;
         after_lvec_q <= push && (push_pkt.kind == PSSQ_K_LVEC)
            && (push_pkt.word_position[`PSSQ_SLOT_W-1:0] != `PSSQ_LAST_SLOT);
      end
   end

   a_biw_zero_dropped: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R2
      push |-> !(push_pkt.kind == PSSQ_K_BIW && push_pkt.word_position == `PSSQ_FIRST_POS))
      else $error("leading block info word forwarded");
   a_biw_report_gate: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R3
      push && push_pkt.kind == PSSQ_K_BIW |-> biw_report_en)
      else $error("block info packet while reporting disabled");
   a_phase_order: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R1
      push && any_q |-> push_pkt.phase >= last_ph_q)
      else $error("phase order broken");
   a_position_order: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R13
      push && any_q && push_pkt.phase == last_ph_q |-> push_pkt.word_position > last_pos_q)
      else $error("word position order broken");
   a_phase_count: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R4
      push |-> push_pkt.phase <= nph)
      else $error("phase beyond rate");
   a_long_addr_pair: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R8
      push && push_pkt.kind == PSSQ_K_LADDR2 |-> prev_laddr1_q
         && push_pkt.data[2*`PSSQ_DATA_W-1:`PSSQ_DATA_W] == prev_data_q)
      else $error("long address halves not merged");
   a_long_vec_msg: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R9
      emit && cur_ok && after_lvec_q |-> push && push_pkt.kind == PSSQ_K_MSG)
      else $error("word after long vector not sent as message");
   a_stall_holds: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R1
      pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_out))
      else $error("packet lost under stall");

   c_block_walked: cover property (@(posedge ref_clk) disable iff (!rst_n_q)
      state_q == PSSQ_WALK ##1 state_q == PSSQ_COLLECT);
   c_long_vector: cover property (@(posedge ref_clk) disable iff (!rst_n_q)
      push && push_pkt.kind == PSSQ_K_LVEC);
   c_buffer_full: cover property (@(posedge ref_clk) disable iff (!rst_n_q)
      count_q == 2'h2 && !pkt_ready);
endmodule : pssq_sequencer
`default_nettype wire

/* test/pssq_host_model.sv */
// Purpose: host side of the packet stream, accepting packets promptly or slowly
// Assumes: the host only answers with ready, no data flows back
// Notes:   slow mode opens ready one cycle in three to stall the buffer
`timescale 1ns/1ps
`default_nettype none
module pssq_host_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // mode and handshake
   input wire logic slow,
   output logic pkt_ready
);
   logic [1:0] cnt_q;
   ////////////////////////////////////////
   // stall pattern, changed just after the edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 2'h0;
         pkt_ready <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
         pkt_ready <= !slow || (cnt_q == 2'h2);
      end
   end
endmodule : pssq_host_model
`default_nettype wire

/* test/paging_packet_sequencer_tb.sv */
// Purpose: self-checking bench of the packet sequencer
// Assumes: every block offers all 32 slots, unused ones as idle words
// Notes:   expected packets are queued per block and matched on each pop
`timescale 1ns/1ps
`default_nettype none
`include "pssq_cfg.svh"
module paging_packet_sequencer_tb import pssq_pkg::*;;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic biw_report_en = 1'b0;
   pssq_rate_e rate = PSSQ_R1600;
   logic word_valid = 1'b0;
   logic word_ready;
   pssq_word_s word_in = '0;
   logic pkt_valid;
   logic pkt_ready;
   pssq_pkt_s pkt_out;
   logic slow = 1'b0;
   int err_total = 0;
   int n_checks = 0;
   pssq_pkt_s exp_q[$];
   pssq_pkt_s e;
   pssq_kind_e k[32];
   ////////////////////////////////////////
   // clock and parts
   initial forever #2.5 ref_clk = ~ref_clk;
   pssq_sequencer dut (.ref_clk(ref_clk), .reset_n(reset_n), .biw_report_en(biw_report_en), .rate(rate),
      .word_valid(word_valid), .word_ready(word_ready), .word_in(word_in),
      .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_out(pkt_out));
   pssq_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .pkt_ready(pkt_ready));
   ////////////////////////////////////////
   // match each popped packet with the oldest expected one
   always @(posedge ref_clk) begin
      if (reset_n && pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
         n_checks++;
         e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
         if ({pkt_out.kind, pkt_out.phase, pkt_out.data, pkt_out.aux} !== {e.kind, e.phase, e.data, e.aux} ||
             (e.kind != PSSQ_K_LADDR2 && pkt_out.word_position !== e.word_position)) begin
            err_total++;
            $display("wrong value at %0t: packet kind %0d pos %0d", $time, pkt_out.kind, pkt_out.word_position);
         end
      end
   end
   // offer one block, queue its expected packets, wait until all arrive
   task automatic run_block(input pssq_rate_e r, input logic en, input logic sl, input logic [3:0] blk);
      int nph;
      logic lv;
      logic [20:0] w1;
      pssq_kind_e kk;
      pssq_pkt_s p;
      nph = (r == PSSQ_R6400) ? 4 : (r == PSSQ_R3200) ? 2 : 1;
      lv = 1'b0;
      w1 = '0;
      for (int s = 0; s < nph * 8; s++) begin
         kk = lv ? PSSQ_K_MSG : k[s];
         lv = !lv && (k[s] == PSSQ_K_LVEC) && (s[2:0] != 3'h7);
         p = '0;
         p.kind = kk;
         p.phase = s[4:3];
         p.word_position = {blk, s[2:0]};
         p.data = {21'h0, blk, s[4:0], 12'hA5C};
         p.aux = {blk, s[4:0], 5'h13};
         if (kk == PSSQ_K_LADDR1) w1 = {blk, s[4:0], 12'hA5C};
         if (kk == PSSQ_K_LADDR2) p.data = {w1, blk, s[4:0], 12'hA5C};
         if (kk inside {PSSQ_K_ADDR, PSSQ_K_LADDR2, PSSQ_K_VEC, PSSQ_K_LVEC, PSSQ_K_MSG} ||
             (kk == PSSQ_K_BIW && en && p.word_position != `PSSQ_FIRST_POS)) exp_q.push_back(p);
      end
      @(posedge ref_clk);
      rate <= r;
      biw_report_en <= en;
      slow <= sl;
      for (int s = 0; s < 32; s++) begin
         word_valid <= 1'b1;
         word_in <= {k[s], s[4:3], blk, s[2:0], blk, s[4:0], 12'hA5C, blk, s[4:0], 5'h13, s == 31};
         do @(negedge ref_clk); while (word_ready !== 1'b1);
         @(posedge ref_clk);
      end
      word_valid <= 1'b0;
      @(negedge ref_clk);
      n_checks++;
      if (word_ready !== 1'b0) begin
         err_total++;
         $display("wrong value at %0t: words accepted during the walk", $time);
      end
      for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge ref_clk);
      repeat (10) @(posedge ref_clk);
      n_checks++;
      if (exp_q.size() != 0) begin
         err_total++;
         $display("wrong value at %0t: %0d packets missing", $time, exp_q.size());
      end
      exp_q.delete();
   endtask : run_block
   // two phases, reporting on, long address and long vector
   task automatic t_two_phase();
      k = '{default: PSSQ_K_IDLE};
      k[0] = PSSQ_K_BIW;
      k[3] = PSSQ_K_ADDR;
      k[4] = PSSQ_K_ADDR;
      k[7] = PSSQ_K_VEC;
      k[8] = PSSQ_K_BIW;
      k[9] = PSSQ_K_BIW;
      k[11] = PSSQ_K_BIW;
      k[13] = PSSQ_K_LADDR1;
      k[14] = PSSQ_K_LADDR2;
      k[26] = PSSQ_K_ADDR;
      run_block(PSSQ_R3200, 1'b1, 1'b0, 4'h0);
      k = '{default: PSSQ_K_IDLE};
      k[0] = PSSQ_K_VEC;
      for (int i = 1; i < 8; i++) k[i] = PSSQ_K_MSG;
      k[10] = PSSQ_K_LVEC;
      k[11] = PSSQ_K_ADDR;
      k[14] = PSSQ_K_MSG;
      k[15] = PSSQ_K_MSG;
      run_block(PSSQ_R3200, 1'b1, 1'b0, 4'h1);
      $display("test two_phase done");
   endtask : t_two_phase
   // four phases, reporting off, host stalling
   task automatic t_four_phase_stall();
      k = '{default: PSSQ_K_IDLE};
      k[0] = PSSQ_K_BIW;
      k[1] = PSSQ_K_BIW;
      k[13] = PSSQ_K_LVEC;
      k[14] = PSSQ_K_MSG;
      k[20] = PSSQ_K_ADDR;
      k[30] = PSSQ_K_LADDR1;
      k[31] = PSSQ_K_LADDR2;
      run_block(PSSQ_R6400, 1'b0, 1'b1, 4'h2);
      $display("test four_phase_stall done");
   endtask : t_four_phase_stall
   // one phase only, later phases ignored
   task automatic t_one_phase();
      k = '{default: PSSQ_K_IDLE};
      k[2] = PSSQ_K_BIW;
      k[5] = PSSQ_K_VEC;
      k[9] = PSSQ_K_ADDR;
      run_block(PSSQ_R1600, 1'b1, 1'b0, 4'h3);
      $display("test one_phase done");
   endtask : t_one_phase
   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_two_phase();
      t_four_phase_stall();
      t_one_phase();
      report_and_stop();
   end
   // watchdog, far beyond the few hundred cycles the blocks need
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
endmodule : paging_packet_sequencer_tb
`default_nettype wire
